// ==== hdl/slpe_top.sv ====
// Sixteen-bit link mode period sequencer and channel mapper
//
// The address map and strobed register access were decided locally.
`default_nettype none
module slpe_top #(
  parameter logic PACKED_SUPPORT = 1'b1, // Mode implemented in this build
  parameter int LEN_W = 12 // Width of the request length field
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Source timing
  input wire logic HSYNC_I,
  input wire logic VSYNC_I,
  // Data period request
  input wire logic REQ_VALID_I,
  input wire logic REQ_ISLAND_I,
  input wire logic [LEN_W-1:0] REQ_LEN_I,
  output logic REQ_READY_O,
  // Pixel stream
  input wire logic [15:0] PIX_I,
  output logic PIX_TAKE_O,
  // Packet stream, subpacket n bytes are packet bytes 7n..7n+6
  input wire logic [31:0] PKT_HDR_I,
  input wire logic [255:0] PKT_BLK_I,
  output logic PKT_TAKE_O,
  // Channel characters before the code tables
  output slpe_pkg::slpe_kind_e CH0_KIND_O,
  output logic [9:0] CH0_DATA_O,
  output slpe_pkg::slpe_kind_e CH1_KIND_O,
  output logic [9:0] CH1_DATA_O,
  output logic CRYPT_OK_O,
  output logic PACKED_SUPPORT_O
);
  import slpe_pkg::*;

  slpe_state_e state_reg; // Period sequencer
  slpe_state_e state_next;
  logic [4:0] cnt_reg; // Character count inside a period
  logic [4:0] cnt_next;
  logic [LEN_W-1:0] left_reg; // Pixels or packets left after this one
  logic [LEN_W-1:0] left_next;
  logic island_reg; // Type of the pending data period
  logic en_reg; // Mode enable from software
  logic [1:0] ctl_idle_reg; // Control bits three/two outside preamble
  logic [15:0] pkt_cnt_reg; // Packets sent, wraps
  slpe_kind_e ch0_kind_next;
  slpe_kind_e ch1_kind_next;
  logic [9:0] ch0_data_next;
  logic [9:0] ch1_data_next;
  logic crypt_next;
  logic hdr_bit; // Serial header bit this clock
  logic [7:0] pkt_byte; // Channel 1 packet byte this clock
  logic [1:0] syncs; // {vertical, horizontal}
  logic [31:0] rdata_next;

  assign syncs = {VSYNC_I, HSYNC_I};
  // Support flag comes straight from the build parameter
  assign PACKED_SUPPORT_O = PACKED_SUPPORT;

  // Requests only taken in control period and when enabled
  assign REQ_READY_O = en_reg && (state_reg == SLPE_S_CTRL);
  // One pixel consumed per active video clock
  assign PIX_TAKE_O = (state_reg == SLPE_S_VACT);
  // Packet taken as the leading guard ends or the previous packet ends
  assign PKT_TAKE_O = ((state_reg == SLPE_S_IGBL) && (cnt_reg == SLPE_GUARD_LAST))
    || ((state_reg == SLPE_S_IPKT) && (cnt_reg == SLPE_PKT_LAST)
    && (left_reg != '0));

  // Header and subpacket striping lives in the small holder
  slpe_pkt_ser u_ser (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .load_i(PKT_TAKE_O),
    .hdr_i(PKT_HDR_I),
    .blk_i(PKT_BLK_I),
    .idx_i(cnt_reg),
    .hdr_bit_o(hdr_bit),
    .byte_o(pkt_byte)
  );

  // Next period state and counters
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 5'h01;
    left_next = left_reg;
    case (state_reg)
      SLPE_S_CTRL: begin
        cnt_next = 5'h00;
        if (REQ_VALID_I && REQ_READY_O) begin
          // Every data period is announced by a preamble
          state_next = SLPE_S_PRE;
          // Zero length counts as one
          left_next = (REQ_LEN_I == '0) ? '0 : REQ_LEN_I - 1'b1;
        end
      end
      SLPE_S_PRE: begin
        if (cnt_reg == SLPE_PRE_LAST) begin
          cnt_next = 5'h00;
          state_next = island_reg ? SLPE_S_IGBL : SLPE_S_VGB;
        end
      end
      SLPE_S_VGB: begin
        if (cnt_reg == SLPE_GUARD_LAST) begin
          state_next = SLPE_S_VACT;
        end
      end
      SLPE_S_VACT: begin
        // No trailing guard after video
        if (left_reg == '0) begin
          state_next = SLPE_S_CTRL;
        end else begin
          left_next = left_reg - 1'b1;
        end
      end
      SLPE_S_IGBL: begin
        if (cnt_reg == SLPE_GUARD_LAST) begin
          cnt_next = 5'h00;
          state_next = SLPE_S_IPKT;
        end
      end
      SLPE_S_IPKT: begin
        if (cnt_reg == SLPE_PKT_LAST) begin
          cnt_next = 5'h00;
          if (left_reg == '0) begin
            state_next = SLPE_S_IGBT;
          end else begin
            left_next = left_reg - 1'b1;
          end
        end
      end
      SLPE_S_IGBT: begin
        if (cnt_reg == SLPE_GUARD_LAST) begin
          state_next = SLPE_S_CTRL;
        end
      end
      default: begin
        state_next = SLPE_S_CTRL;
        cnt_next = 5'h00;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= SLPE_S_CTRL;
      cnt_reg <= 5'h00;
      left_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      left_reg <= left_next;
    end
  end

  // Period type is latched with the request so the preamble stays identical
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      island_reg <= 1'b0;
    end else if (REQ_VALID_I && REQ_READY_O) begin
      island_reg <= REQ_ISLAND_I;
    end
  end

  // Channel character selection
  always_comb begin
    // Control: syncs on channel 0, bits three/two on channel 1
    // Bits zero and one are not sent; the receiver rebuilds them
    ch0_kind_next = SLPE_K_CTRL;
    ch0_data_next = {8'h00, syncs};
    ch1_kind_next = SLPE_K_CTRL;
    ch1_data_next = {8'h00, ctl_idle_reg};
    crypt_next = 1'b0;
    case (state_reg)
      SLPE_S_CTRL: begin
        crypt_next = 1'b0;
      end
      SLPE_S_PRE: begin
        // Only channel 1 carries the pattern, channel 0 keeps syncs
        ch1_data_next = {8'h00, island_reg ? SLPE_PRE_ISLAND : SLPE_PRE_VIDEO};
      end
      SLPE_S_VGB: begin
        // Guard characters never encrypted
        ch0_kind_next = SLPE_K_FIXED;
        ch0_data_next = SLPE_GB_VID_CH0;
        ch1_kind_next = SLPE_K_FIXED;
        ch1_data_next = SLPE_GB_VID_CH1;
      end
      SLPE_S_VACT: begin
        // Low pixel byte on channel 0, high byte on channel 1
        ch0_kind_next = SLPE_K_VIDEO;
        ch0_data_next = {2'b00, PIX_I[7:0]};
        ch1_kind_next = SLPE_K_VIDEO;
        ch1_data_next = {2'b00, PIX_I[15:8]};
        crypt_next = 1'b1;
      end
      SLPE_S_IGBL, SLPE_S_IGBT: begin
        // Value 0xC..0xF picked by the sync levels
        ch0_kind_next = SLPE_K_TERC4;
        ch0_data_next = {6'h00, SLPE_GB_ISL_HI, syncs};
        ch1_kind_next = SLPE_K_FIXED;
        ch1_data_next = SLPE_GB_ISL_CH1;
      end
      SLPE_S_IPKT: begin
        // Four-bit value: header on bit 2, syncs on bits 1:0
        ch0_kind_next = SLPE_K_TERC4;
        ch0_data_next = {6'h00, 1'b0, hdr_bit, syncs};
        // Subpacket bits as an eight-bit video word
        ch1_kind_next = SLPE_K_VIDEO;
        ch1_data_next = {2'b00, pkt_byte};
        crypt_next = 1'b1;
      end
      default: begin
        crypt_next = 1'b0;
      end
    endcase
  end

  // Channel outputs come from flops, one clock behind the sequencer
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      CH0_KIND_O <= SLPE_K_CTRL;
      CH0_DATA_O <= 10'h000;
      CH1_KIND_O <= SLPE_K_CTRL;
      CH1_DATA_O <= 10'h000;
      CRYPT_OK_O <= 1'b0;
    end else begin
      CH0_KIND_O <= ch0_kind_next;
      CH0_DATA_O <= ch0_data_next;
      CH1_KIND_O <= ch1_kind_next;
      CH1_DATA_O <= ch1_data_next;
      CRYPT_OK_O <= crypt_next;
    end
  end

  // Packet counter for software
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pkt_cnt_reg <= 16'h0000;
    end else if (PKT_TAKE_O) begin
      pkt_cnt_reg <= pkt_cnt_reg + 16'h0001;
    end
  end

  // Control register write; disabling only stops new requests
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      en_reg <= SLPE_CTRL_RESET[SLPE_CTRL_EN_BIT];
      ctl_idle_reg <= SLPE_CTRL_RESET[SLPE_CTRL_CTL_LSB +: 2];
    end else if (WR_I && (ADDR_I == SLPE_OFS_CTRL)) begin
      en_reg <= WDATA_I[SLPE_CTRL_EN_BIT];
      ctl_idle_reg <= WDATA_I[SLPE_CTRL_CTL_LSB +: 2];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (ADDR_I)
      SLPE_OFS_CAP: rdata_next[SLPE_CAP_PACKED_BIT] = PACKED_SUPPORT;
      SLPE_OFS_CTRL: rdata_next[2:0] = {ctl_idle_reg, en_reg};
      SLPE_OFS_STATUS: rdata_next[2:0] = state_reg;
      SLPE_OFS_PKTCNT: rdata_next[15:0] = pkt_cnt_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      RDATA_O <= rdata_next;
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

  // Checks on the sequence
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  a_pre_eight_long: assert property (
    (state_reg == SLPE_S_CTRL && state_next == SLPE_S_PRE) |=>
      (state_reg == SLPE_S_PRE)[*8] ##1 (state_reg != SLPE_S_PRE))
    else $error("preamble not eight characters");
  a_pre_type_code: assert property (
    (state_reg == SLPE_S_PRE) |=> (CH1_KIND_O == SLPE_K_CTRL)
      && (CH1_DATA_O[1:0] == (island_reg ? 2'b01 : 2'b00))
      && (CH0_DATA_O[1:0] == $past(syncs)))
    else $error("wrong preamble character");
  a_vid_guard_chars: assert property (
    (state_reg == SLPE_S_VGB) |=> (CH0_DATA_O == 10'h133)
      && (CH1_DATA_O == 10'h2CC) && !CRYPT_OK_O)
    else $error("bad video guard band");
  a_isl_guard_ch0: assert property (
    (state_reg == SLPE_S_IGBL || state_reg == SLPE_S_IGBT) |=>
      (CH0_KIND_O == SLPE_K_TERC4) && (CH0_DATA_O[3:2] == 2'b11)
      && (CH0_DATA_O[1:0] == $past(syncs)) && (CH1_DATA_O == 10'h133)
      && !CRYPT_OK_O)
    else $error("bad island guard band");
  a_pkt_length: assert property (
    (state_reg == SLPE_S_IPKT && cnt_reg == 5'h00) |->
      ##31 (state_reg == SLPE_S_IPKT && cnt_reg == 5'h1F))
    else $error("packet not 32 clocks");
  a_isl_trail_guard: assert property (
    (state_reg == SLPE_S_IPKT && cnt_reg == 5'h1F && left_reg == '0) |=>
      (state_reg == SLPE_S_IGBT) ##1 (state_reg == SLPE_S_IGBT)
      ##1 (state_reg == SLPE_S_CTRL))
    else $error("island trailer wrong");
  a_vid_no_trail: assert property (
    (state_reg == SLPE_S_VACT && left_reg == '0) |=> (state_reg == SLPE_S_CTRL)
      ##1 (CH0_KIND_O == SLPE_K_CTRL && CH1_KIND_O == SLPE_K_CTRL))
    else $error("video period has a trailer");
  a_lead_then_pkt: assert property (
    $rose(state_reg == SLPE_S_IGBL) |-> ##2 (state_reg == SLPE_S_IPKT)
      && ($past(PKT_TAKE_O) == 1'b1))
    else $error("packet does not follow guard");
  a_isl_ch1_video: assert property (
    (state_reg == SLPE_S_IPKT) |=> (CH1_KIND_O == SLPE_K_VIDEO)
      && (CH1_DATA_O[7:0] == $past(pkt_byte)) && (CH0_DATA_O[2] == $past(hdr_bit)))
    else $error("island channel 1 not packet data");
  a_cap_read_flag: assert property (
    (RD_I && ADDR_I == SLPE_OFS_CAP) |=> (RDATA_O[0] == PACKED_SUPPORT))
    else $error("capability flag misread");
endmodule
`default_nettype wire

// ==== hdl/slpe_pkg.sv ====
// Constants and types for the sixteen-bit link period encoder
`default_nettype none
package slpe_pkg;
  // Register offsets (byte addresses)
  localparam logic [3:0] SLPE_OFS_CAP = 4'h0;
  localparam logic [3:0] SLPE_OFS_CTRL = 4'h4;
  localparam logic [3:0] SLPE_OFS_STATUS = 4'h8;
  localparam logic [3:0] SLPE_OFS_PKTCNT = 4'hC;
  // Control register fields
  localparam int SLPE_CTRL_EN_BIT = 0;
  localparam int SLPE_CTRL_CTL_LSB = 1;
  localparam logic [2:0] SLPE_CTRL_RESET = 3'h0;
  // Capability register field
  localparam int SLPE_CAP_PACKED_BIT = 0;
  // Last character count of each period, length minus one
  localparam logic [4:0] SLPE_PRE_LAST = 5'h07;
  localparam logic [4:0] SLPE_GUARD_LAST = 5'h01;
  localparam logic [4:0] SLPE_PKT_LAST = 5'h1F;
  // Fixed guard band characters, bit order [9:0]
  localparam logic [9:0] SLPE_GB_VID_CH0 = 10'h133;
  localparam logic [9:0] SLPE_GB_VID_CH1 = 10'h2CC;
  localparam logic [9:0] SLPE_GB_ISL_CH1 = 10'h133;
  // Upper two bits of the island guard band channel 0 value
  localparam logic [1:0] SLPE_GB_ISL_HI = 2'h3;
  // Preamble control bits {three, two}
  localparam logic [1:0] SLPE_PRE_VIDEO = 2'h0;
  localparam logic [1:0] SLPE_PRE_ISLAND = 2'h1;
  // Character coding selected for a channel
  typedef enum logic [1:0] {
    SLPE_K_CTRL = 2'b00,
    SLPE_K_TERC4 = 2'b01,
    SLPE_K_VIDEO = 2'b10,
    SLPE_K_FIXED = 2'b11
  } slpe_kind_e;
  // Link sequencer states
  typedef enum logic [2:0] {
    SLPE_S_CTRL = 3'b000,
    SLPE_S_PRE = 3'b001,
    SLPE_S_VGB = 3'b010,
    SLPE_S_VACT = 3'b011,
    SLPE_S_IGBL = 3'b100,
    SLPE_S_IPKT = 3'b101,
    SLPE_S_IGBT = 3'b110
  } slpe_state_e;
endpackage
`default_nettype wire

// ==== hdl/slpe_pkt_ser.sv ====
// Packet holder that stripes header and four error-protected blocks per clock
`default_nettype none
module slpe_pkt_ser (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [31:0] hdr_i,
  input wire logic [255:0] blk_i,
  input wire logic [4:0] idx_i,
  output logic hdr_bit_o,
  output logic [7:0] byte_o
);
  import slpe_pkg::*;

  logic [31:0] hdr_reg; // Header with its parity
  logic [255:0] blk_reg; // Block k is subpacket k, packet bytes 7k..7k+6
  logic [5:0] even_idx; // Even bit of the pair sent this clock

  // Whole packet is captured at once so the source may change it freely
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hdr_reg <= 32'h0000_0000;
      blk_reg <= '0;
    end else if (load_i) begin
      hdr_reg <= hdr_i;
      blk_reg <= blk_i;
    end
  end

  assign even_idx = {idx_i, 1'b0};
  // Header goes out serially, bit 0 first
  assign hdr_bit_o = hdr_reg[idx_i];

  // Block k on byte bits k and k+4, even bit low
  for (genvar k = 0; k < 4; k++) begin : g_blk
    assign byte_o[k] = blk_reg[k * 64 + int'(even_idx)];
    assign byte_o[k + 4] = blk_reg[k * 64 + int'(even_idx) + 1];
  end
endmodule
`default_nettype wire

// ==== verif/slpe_sink_mdl.sv ====
// Sink-side model that finds data period starts on channel 1
`default_nettype none
module slpe_sink_mdl (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire slpe_pkg::slpe_kind_e ch1_kind_i,
  input wire logic [9:0] ch1_data_i,
  output logic [7:0] starts_o,
  output logic island_o,
  output logic [1:0] ctl01_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import slpe_pkg::*;
  logic [3:0] run_reg; // Identical control pairs in a row
  logic [1:0] last_reg; // Previous control pair
  logic was_ctrl_reg; // Previous character was control
  // Bits zero and one never cross the link, so rebuild them here
  assign ctl01_o = 2'h1;
  // Run counter saturates at eight so long idle runs cannot wrap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_reg <= 4'h0;
      last_reg <= 2'h0;
      was_ctrl_reg <= 1'b0;
      starts_o <= 8'h00;
      island_o <= 1'b0;
    end else if (ch1_kind_i == SLPE_K_CTRL) begin
      if (was_ctrl_reg && ch1_data_i[1:0] == last_reg) begin
        if (run_reg != 4'h8) run_reg <= run_reg + 4'h1;
      end else begin
        run_reg <= 4'h1;
      end
      last_reg <= ch1_data_i[1:0];
      was_ctrl_reg <= 1'b1;
    end else begin
      // First guard character after a complete preamble
      if (was_ctrl_reg && run_reg == 4'h8) begin
        starts_o <= starts_o + 8'h01;
        island_o <= (last_reg == 2'h1);
      end
      was_ctrl_reg <= 1'b0;
      run_reg <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/slpe_top_tb.sv ====
// Self-checking bench for the sixteen-bit link period encoder
`default_nettype none
module slpe_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import slpe_pkg::*;
  // Scrambles the four blocks so a swapped stripe shows
  localparam logic [255:0] KEY = {64'h0123456789ABCDEF, 64'hFEDCBA9876543210,
    64'h00FF00FF0F0F3333, 64'h5555AAAA3C3CC3C3};
  logic clk_sys, nrst, wr, rd, hs, vs, rv, risl, rdy, ptk, ktk, cok, psup, isl_seen;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, tmp;
  logic [31:0] hdr = 32'hA5C30F12; // Header pattern of index 0, fed by the feeder only
  logic [11:0] rlen;
  logic [15:0] pix = 16'h3C5A; // Pixel pattern of index 0, fed by the feeder only
  logic [255:0] blk;
  logic [9:0] d0, d1;
  logic [7:0] starts;
  logic [1:0] ctl01;
  slpe_kind_e k0, k1;
  int failures = 0, checks = 0, cyc = 0, pix_n = 0, pkt_n = 0;
  assign blk = {8{hdr}} ^ KEY;
  slpe_top #(.PACKED_SUPPORT(1'b1), .LEN_W(12)) dut (.CLK_SYS_I(clk_sys), .NRST_I(nrst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .HSYNC_I(hs), .VSYNC_I(vs), .REQ_VALID_I(rv), .REQ_ISLAND_I(risl), .REQ_LEN_I(rlen),
    .REQ_READY_O(rdy), .PIX_I(pix), .PIX_TAKE_O(ptk), .PKT_HDR_I(hdr), .PKT_BLK_I(blk),
    .PKT_TAKE_O(ktk), .CH0_KIND_O(k0), .CH0_DATA_O(d0), .CH1_KIND_O(k1), .CH1_DATA_O(d1),
    .CRYPT_OK_O(cok), .PACKED_SUPPORT_O(psup));
  slpe_sink_mdl sink (.clk_i(clk_sys), .nrst_i(nrst), .ch1_kind_i(k1), .ch1_data_i(d1),
    .starts_o(starts), .island_o(isl_seen), .ctl01_o(ctl01));
  // Pixel and packet patterns, distinct per index
  function automatic logic [15:0] pv(input int n);
    return 16'h3C5A + 16'(n) * 16'h1111;
  endfunction
  function automatic logic [31:0] hv(input int n);
    return 32'hA5C30F12 ^ (32'(n) * 32'h01042083);
  endfunction
  // Only the bits a coding kind carries are compared
  function automatic logic [9:0] msk(input slpe_kind_e k);
    case (k)
      SLPE_K_CTRL: return 10'h003;
      SLPE_K_TERC4: return 10'h00F;
      SLPE_K_VIDEO: return 10'h0FF;
      default: return 10'h3FF;
    endcase
  endfunction
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Register port master, one-cycle strobes
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // One character on both channels
  task automatic pos(input slpe_kind_e e0, input logic [9:0] x0, input slpe_kind_e e1,
                     input logic [9:0] x1, input logic c);
    chk("ch0 kind", e0, k0);
    chk("ch0 data", x0, d0 & msk(e0));
    chk("ch1 kind", e1, k1);
    chk("ch1 data", x1, d1 & msk(e1));
    chk("crypt", c, cok);
  endtask
  // Feed the next pixel or packet once the current one is taken
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (ptk === 1'b1) begin
      pix_n <= pix_n + 1;
      pix <= pv(pix_n + 1);
    end
    if (ktk === 1'b1) begin
      pkt_n <= pkt_n + 1;
      hdr <= hv(pkt_n + 1);
    end
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  // One data period of either type, checked character by character
  task automatic run(input logic isl, input int len, input logic [1:0] s);
    int n, q, b0, bp, nst, m;
    logic [31:0] h;
    logic [255:0] e;
    logic [7:0] by;
    // Zero length still sends one pixel or packet
    m = (len == 0) ? 1 : len;
    n = isl ? 12 + 32 * m : 10 + m;
    b0 = pix_n;
    bp = pkt_n;
    nst = starts;
    @(posedge clk_sys);
    {vs, hs} <= s;
    repeat (3) @(posedge clk_sys);
    #1 pos(SLPE_K_CTRL, {8'h00, s}, SLPE_K_CTRL, 10'h002, 1'b0);
    chk("ready", 1'b1, rdy);
    @(posedge clk_sys);
    rv <= 1'b1;
    risl <= isl;
    rlen <= 12'(len);
    q = 0;
    do begin
      @(posedge clk_sys);
      q++;
    end while (rdy !== 1'b1 && q < 20);
    rv <= 1'b0;
    #1;
    for (int j = 0; j <= n; j++) begin
      @(posedge clk_sys);
      #1;
      if (j == n) begin
        pos(SLPE_K_CTRL, {8'h00, s}, SLPE_K_CTRL, 10'h002, 1'b0);
      end else if (j < 8) begin
        pos(SLPE_K_CTRL, {8'h00, s}, SLPE_K_CTRL, {9'h000, isl}, 1'b0);
      end else if (j < 10 || (isl && j >= n - 2)) begin
        if (isl) pos(SLPE_K_TERC4, {6'h00, 2'b11, s}, SLPE_K_FIXED, 10'h133, 1'b0);
        else pos(SLPE_K_FIXED, 10'h133, SLPE_K_FIXED, 10'h2CC, 1'b0);
      end else if (!isl) begin
        h = {16'h0000, pv(b0 + j - 10)};
        pos(SLPE_K_VIDEO, {2'h0, h[7:0]}, SLPE_K_VIDEO, {2'h0, h[15:8]}, 1'b1);
      end else begin
        q = j - 10;
        h = hv(bp + q / 32);
        e = {8{h}} ^ KEY;
        for (int k = 0; k < 4; k++) begin
          by[k] = e[64 * k + 2 * (q % 32)];
          by[k + 4] = e[64 * k + 2 * (q % 32) + 1];
        end
        pos(SLPE_K_TERC4, {6'h00, 1'b0, h[q % 32], s}, SLPE_K_VIDEO, {2'h0, by}, 1'b1);
      end
    end
    chk("pixels taken", isl ? 0 : m, pix_n - b0);
    chk("packets taken", isl ? m : 0, pkt_n - bp);
    chk("starts", nst + 1, starts);
    chk("island seen", isl, isl_seen);
    chk("bits zero one", 2'h1, ctl01);
  endtask
  // Clock at 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    {nrst, wr, rd, hs, vs, rv, risl} = 7'h00;
    addr = 4'h0;
    wdata = 32'h0;
    rlen = 12'h000;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_reg(4'h0, tmp);
    chk("cap", 32'h1, tmp & 32'h1);
    chk("support pin", 1'b1, psup);
    chk("ready while off", 1'b0, rdy);
    wr_reg(4'h0, 32'h0);
    rd_reg(4'h0, tmp);
    chk("cap after write", 32'h1, tmp & 32'h1);
    rd_reg(4'h2, tmp);
    chk("unmapped", 32'h0, tmp);
    wr_reg(4'h4, 32'h5);
    rd_reg(4'h4, tmp);
    chk("ctrl readback", 32'h5, tmp);
    rd_reg(4'h8, tmp);
    chk("status idle", {29'h0, SLPE_S_CTRL}, tmp);
    // Read data must not linger past its one cycle
    @(posedge clk_sys);
    #1 chk("rdata cleared", 32'h0, rdata);
    run(1'b0, 2, 2'b00);
    run(1'b0, 0, 2'b01);
    run(1'b1, 0, 2'b00);
    run(1'b1, 1, 2'b01);
    run(1'b1, 2, 2'b10);
    run(1'b1, 1, 2'b11);
    run(1'b0, 1, 2'b11);
    rd_reg(4'hC, tmp);
    chk("packet count", 32'h5, tmp & 32'hFFFF);
    stop_test();
  end
endmodule
`default_nettype wire
